/* design/rct_reset_cause.sv */
/*
 reset-cause tracking and start-up time-out sequencer.
 holds the power control register, the status flags, the program counter
 load for each reset or wake-up, and the internal reset release.
 assumes one 20 MHz clock; porEvt, master clear, watchdog and wake inputs
 are asynchronous pins and are synchronised here; the register port
 master follows a one-cycle strobe protocol.
*/
// Local design decision: strobed register access.
// Behaviour
// - power-on clears power_on_flag; no other event touches it
// - software may set or clear power_on_flag; otherwise it holds until next power-on
// - delay: crystal 72ms+1024Tosc, or 1024Tosc; rc 72ms or none
// - power-on sets both flags, status 0001 1xxx, pc 000h
// - watchdog reset: pc 000h, upper four status bits cleared
// - master clear awake: pc 000h, upper three status bits cleared
// - master clear asleep: pc 000h, 0001 0uuu status
// - watchdog wake: pc+1, both flags cleared
// - interrupt wake: pc+1 or vector 0004h, flags 1 and 0
// - unimplemented power control bits read zero
// - core held in reset while power-up delay timer runs
// - oscillator start-up counts 1024 cycles, crystal only, power-on or wake
`timescale 1ns/1ps
module rct_reset_cause
   import rct_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_CNT = rct_pkg::POWERUP_DELAY_TIMER_CYCLES,
   parameter int OST_CNT  = rct_pkg::OST_OSC_CYCLES
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic                    porEvt,
   input  wire logic                    masterClearB,
   input  wire logic                    watchdogEvt,
   input  wire logic                    irqWakeEvt,
   input  wire logic                    sleepEnter,
   input  wire logic                    oscTick,
   input  wire logic                    globalIrqEnable,
   input  wire logic [12:0]             pcCurrent,
   input  wire logic [7:0]              statusIn,
   input  wire logic [7:0]              regAddr,
   input  wire logic [7:0]              regWdata,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   output logic      [7:0]              regRdata,
   output logic      [12:0]             pcLoad,
   output logic                         pcLoadStb,
   output logic      [7:0]              status,
   output logic                         coreResetB,
   output logic                         asleep,
   output logic                         irq
);
   localparam int TW = 22;
   // flag masks built from the field positions
   localparam logic [7:0] WDOG_MASK  = 8'(1 << WDOG_BIT);
   localparam logic [7:0] SLEEP_MASK = 8'(1 << SLEEP_BIT);
   localparam logic [7:0] FLAGS_MASK = WDOG_MASK | SLEEP_MASK;

   // both delays share one timer width; refuse counts it cannot hold
   if (POWERUP_DELAY_TIMER_CNT < 1 || POWERUP_DELAY_TIMER_CNT >= (1 << TW) ||
       OST_CNT < 1 || OST_CNT >= (1 << TW)) begin : g_bad_cnt
      $error("rct_reset_cause: delay counts out of range");
   end

   logic       rstS1, rstB;
   logic [3:0] pinS;
   logic       porS, mclrBS, wdtS, wakeS;
   logic       powerOnFlag;
   logic       porSeen;
   rct_osc_e   oscMode;
   logic       pwrtDisable;
   logic [EV_NUM-1:0] evStat, evMask;
   rct_state_e state, next_state;
   logic       ostTick;
   logic       pwrtLoad, ostLoad, pwrtBusy, pwrtDone, ostBusy, ostDone;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rstS1 <= 1'b0;
         rstB  <= 1'b0;
      end else begin
         rstS1 <= 1'b1;
         rstB  <= rstS1;
      end
   end

   rct_sync #(.WIDTH(4)) uPinSync (
      .clk  (clk_sys),
      .rstB (rstB),
      .din  ({porEvt, ~masterClearB, watchdogEvt, irqWakeEvt}),
      .dout (pinS)
   );
   assign porS   = pinS[3];
   assign mclrBS = ~pinS[2];
   assign wdtS   = pinS[1];
   assign wakeS  = pinS[0];

   // oscillator tick is a pin too; edge seen after sync only
   logic oscS, oscSD;
   rct_sync #(.WIDTH(1)) uOscSync (
      .clk  (clk_sys),
      .rstB (rstB),
      .din  (oscTick),
      .dout (oscS)
   );
   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB) oscSD <= 1'b0;
      else       oscSD <= oscS;
   end
   assign ostTick = oscS & ~oscSD;

   // event decode; power-on has priority, then master clear, then watchdog
   logic porEdge, porD, wdtD, wakeD;
   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB) begin
         porD  <= 1'b0;
         wdtD  <= 1'b0;
         wakeD <= 1'b0;
      end else begin
         porD  <= porS;
         wdtD  <= wdtS;
         wakeD <= wakeS;
      end
   end
   // a freshly released reset counts as power-on
   assign porEdge = (porS & ~porD) | ~porSeen;
   wire wdtEdge   = wdtS & ~wdtD;
   wire wakeEdge  = wakeS & ~wakeD;
   wire isSleep   = (state == RCT_ASLEEP);
   wire evPor     = porEdge;
   wire evMclr    = !evPor && !mclrBS && (state == RCT_RUN || isSleep);
   wire evWdtRst  = !evPor && !evMclr && wdtEdge && state == RCT_RUN;
   wire evWdtWake = !evPor && !evMclr && wdtEdge && isSleep;
   wire evIrqWake = !evPor && !evMclr && !evWdtWake && wakeEdge && isSleep;
   wire crystal   = (oscMode == RCT_CRYSTAL_LOWPOWER) || (oscMode == RCT_CRYSTAL_STD)
                    || (oscMode == RCT_CRYSTAL_FAST);

   // delay selection
   assign pwrtLoad = evPor && !pwrtDisable;
   assign ostLoad  = crystal && ((evPor && pwrtDisable) || pwrtDone ||
                     evWdtWake || evIrqWake);

   rct_timer #(.WIDTH(TW)) uPwrt (
      .clk     (clk_sys),
      .rstB    (rstB),
      .load    (pwrtLoad),
      .loadVal (TW'(POWERUP_DELAY_TIMER_CNT)),
      .tick    (1'b1),
      .busy    (pwrtBusy),
      .done    (pwrtDone)
   );
   rct_timer #(.WIDTH(TW)) uOst (
      .clk     (clk_sys),
      .rstB    (rstB),
      .load    (ostLoad),
      .loadVal (TW'(OST_CNT)),
      .tick    (ostTick),
      .busy    (ostBusy),
      .done    (ostDone)
   );

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         RCT_HOLD_POWERUP_DELAY_TIMER: begin
            if (pwrtLoad || pwrtBusy)     next_state = RCT_HOLD_POWERUP_DELAY_TIMER;
            else if (ostLoad || ostBusy)  next_state = RCT_HOLD_OST;  // oscillator timer loaded when the power-up delay ends, or at power-on if that delay is off
            else                          next_state = RCT_RUN;
         end
         RCT_HOLD_OST: begin
            if (ostDone)               next_state = RCT_RUN;
         end
         RCT_RUN: begin
            if (sleepEnter)            next_state = RCT_ASLEEP;
         end
         RCT_ASLEEP: begin
            if (ostLoad)               next_state = RCT_HOLD_OST;
            // rc modes wake with no start-up delay
            else if (evMclr || evWdtWake || evIrqWake)
                                       next_state = RCT_RUN;
         end
         default:                      next_state = RCT_HOLD_POWERUP_DELAY_TIMER;
      endcase
      if (evPor) next_state = RCT_HOLD_POWERUP_DELAY_TIMER;
   end

   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB) begin
         state   <= RCT_HOLD_POWERUP_DELAY_TIMER;
         porSeen <= 1'b0;
      end else begin
         state   <= next_state;
         porSeen <= 1'b1;
      end
   end

   // status and program counter loads per event
   wire [7:0] nextStatus =
      evPor     ? (STAT_POR_VAL | (statusIn & ~STAT_MASTER_CLEAR_N_CLR & ~FLAGS_MASK)) :
      evMclr && isSleep ? ((statusIn & ~STAT_MASTER_CLEAR_N_CLR & ~SLEEP_MASK) | WDOG_MASK) :
      evMclr    ? (statusIn & ~STAT_MASTER_CLEAR_N_CLR) :
      evWdtRst  ? (statusIn & ~STAT_WDT_CLR) :
      evWdtWake ? (statusIn & ~FLAGS_MASK) :
      evIrqWake ? ((statusIn & ~SLEEP_MASK) | WDOG_MASK) :
      status;
   wire [12:0] nextPc =
      (evPor || evMclr || evWdtRst) ? PC_RESET :
      (evIrqWake && globalIrqEnable) ? PC_IRQ_VEC : pcCurrent + PC_STEP;
   wire anyEv = evPor | evMclr | evWdtRst | evWdtWake | evIrqWake;

   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB) begin
         status    <= STAT_POR_VAL;
         pcLoad    <= PC_RESET;
         pcLoadStb <= 1'b0;
      end else begin
         status    <= nextStatus;
         pcLoadStb <= anyEv;
         if (anyEv) pcLoad <= nextPc;
      end
   end

   // register decode
   wire selPwr  = (regAddr == ADDR_PWRCTL);
   wire selStat = (regAddr == ADDR_EVSTAT);
   wire selMask = (regAddr == ADDR_EVMASK);
   wire selCfg  = (regAddr == ADDR_CONFIG);
   wire selSt   = (regAddr == ADDR_STATUS);
   wire [7:0] pwrRead  = {6'h00, powerOnFlag, 1'b0};
   wire [7:0] rdMux    = selPwr  ? pwrRead :
                         selStat ? {4'h0, evStat} :
                         selMask ? {4'h0, evMask} :
                         selCfg  ? {4'h0, pwrtDisable, oscMode} :
                         selSt   ? status : ZERO8;
   wire [EV_NUM-1:0] evSet = {evWdtWake | evIrqWake, evWdtRst, evMclr, evPor};

   // power-on flag: written by software, cleared by power-on
   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB)
         powerOnFlag <= 1'b0;
      else if (evPor)
         powerOnFlag <= 1'b0;
      else if (regWr && selPwr)
         powerOnFlag <= regWdata[PWRON_BIT];
   end

   // config and mask writes; event status cleared by read, set wins
   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB) begin
         oscMode     <= RCT_CRYSTAL_STD;
         pwrtDisable <= 1'b0;
         evMask      <= '0;
         evStat      <= '0;
         regRdata    <= ZERO8;
         irq         <= 1'b0;
      end else begin
         if (regWr && selCfg) begin
            oscMode     <= rct_osc_e'(regWdata[2:0]);
            pwrtDisable <= regWdata[3];
         end
         if (regWr && selMask) evMask <= regWdata[EV_NUM-1:0];
         evStat   <= ((regRd && selStat) ? '0 : evStat) | evSet;
         regRdata <= regRd ? rdMux : ZERO8;
         irq      <= |(evStat & evMask);
      end
   end

   always_ff @(posedge clk_sys or negedge rstB) begin
      if (!rstB) begin
         coreResetB <= 1'b0;
         asleep     <= 1'b0;
      end else begin
         coreResetB <= (next_state == RCT_RUN) || (next_state == RCT_ASLEEP);
         asleep     <= (next_state == RCT_ASLEEP);
      end
   end

   // checks
   a_por_flag_clr: assert property (@(posedge clk_sys) disable iff (!rstB)
      evPor |=> !powerOnFlag) else $error("power flag not cleared");
   a_por_flag_hold: assert property (@(posedge clk_sys) disable iff (!rstB)
      !evPor && !(regWr && selPwr) |=> $stable(powerOnFlag)) else $error("flag moved");
   a_rc_no_delay: assert property (@(posedge clk_sys) disable iff (!rstB)
      evPor && pwrtDisable && !crystal |=> ##[1:3] coreResetB) else $error("rc delay");
   a_por_status: assert property (@(posedge clk_sys) disable iff (!rstB)
      evPor |=> status[7:3] == 5'h03 && pcLoad == PC_RESET) else $error("por status");
   a_wdt_status: assert property (@(posedge clk_sys) disable iff (!rstB)
      evWdtRst |=> status[7:4] == 4'h0 && status[3] == $past(statusIn[3]))
      else $error("wdt status");
   a_master_clear_n_status: assert property (@(posedge clk_sys) disable iff (!rstB)
      evMclr && !isSleep |=> status[7:5] == 3'h0 && status[4:0] == $past(statusIn[4:0]))
      else $error("master_clear_n status");
   a_master_clear_n_sleep: assert property (@(posedge clk_sys) disable iff (!rstB)
      evMclr && isSleep |=> status[4:3] == 2'b10) else $error("master_clear_n sleep");
   a_wdt_wake: assert property (@(posedge clk_sys) disable iff (!rstB)
      evWdtWake |=> status[4:3] == 2'b00 && pcLoad == $past(pcCurrent) + PC_STEP)
      else $error("wdt wake");
   a_irq_vector: assert property (@(posedge clk_sys) disable iff (!rstB)
      evIrqWake && globalIrqEnable |=> pcLoad == PC_IRQ_VEC) else $error("vector");
   a_pwr_unimpl: assert property (@(posedge clk_sys) disable iff (!rstB)
      regRd && selPwr |=> (regRdata & 8'hFD) == ZERO8) else $error("unimpl bits");
   a_powerup_delay_timer_hold: assert property (@(posedge clk_sys) disable iff (!rstB)
      pwrtBusy |-> !coreResetB) else $error("released in powerup_delay_timer");
   a_ost_hold: assert property (@(posedge clk_sys) disable iff (!rstB)
      ostBusy && !isSleep |=> !coreResetB) else $error("released in ost");
   a_ost_after: assert property (@(posedge clk_sys) disable iff (!rstB)
      pwrtDone && crystal |=> ostBusy) else $error("ost not chained");
   c_por_seen:  cover property (@(posedge clk_sys) evPor);
   c_wdt_wake:  cover property (@(posedge clk_sys) evWdtWake);
   c_irq_wake:  cover property (@(posedge clk_sys) evIrqWake && globalIrqEnable);
   c_irq_out:   cover property (@(posedge clk_sys) irq);
endmodule : rct_reset_cause

/* design/rct_pkg.sv */
/*
 reset-cause and start-up time-out package: register map, field positions,
 reset values, oscillator modes, delay figures.
 assumes a 20 MHz system clock; used by rct_reset_cause and the bench.
*/
package rct_pkg;
   // register word offsets on the plain register port
   localparam logic [7:0] ADDR_PWRCTL   = 8'h8E;
   localparam logic [7:0] ADDR_STATUS   = 8'h03;
   localparam logic [7:0] ADDR_EVSTAT   = 8'h90;
   localparam logic [7:0] ADDR_EVMASK   = 8'h91;
   localparam logic [7:0] ADDR_CONFIG   = 8'h92;
   // field positions
   localparam int PWRON_BIT   = 1;
   localparam int SLEEP_BIT   = 3;
   localparam int WDOG_BIT    = 4;
   // status loads per event: power-on value and clear masks over the upper five bits
   localparam logic [7:0] STAT_POR_VAL  = 8'h18;
   localparam logic [7:0] STAT_MASTER_CLEAR_N_CLR = 8'hE0;
   localparam logic [7:0] STAT_WDT_CLR  = 8'hF0;
   localparam logic [7:0] PWRCTL_RST    = 8'h00;
   localparam logic [7:0] ZERO8         = 8'h00;
   // program counter values
   localparam logic [12:0] PC_RESET     = 13'h0000;
   localparam logic [12:0] PC_IRQ_VEC   = 13'h0004;
   localparam logic [12:0] PC_STEP      = 13'h0001;
   // event bits in the event status register
   localparam int EV_POR  = 0;
   localparam int EV_MASTER_CLEAR_N = 1;
   localparam int EV_WDT  = 2;
   localparam int EV_WAKE = 3;
   localparam int EV_NUM  = 4;
   // timing: 72 ms power-up delay, 1024 oscillator cycles
   localparam int CLK_HZ          = 20_000_000;
   localparam int POWERUP_DELAY_TIMER_MS         = 72;
   localparam int POWERUP_DELAY_TIMER_CYCLES     = POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000);
   localparam int OST_OSC_CYCLES  = 1024;
   // oscillator modes
   typedef enum logic [2:0] {
      RCT_CRYSTAL_LOWPOWER = 3'h0,
      RCT_CRYSTAL_STD      = 3'h1,
      RCT_CRYSTAL_FAST     = 3'h2,
      RCT_INTERNAL_RC      = 3'h4,
      RCT_EXTERNAL_RC      = 3'h6
   } rct_osc_e;
   // time-out sequencer states, gray along the path
   typedef enum logic [1:0] {
      RCT_HOLD_POWERUP_DELAY_TIMER = 2'b00,
      RCT_HOLD_OST  = 2'b01,
      RCT_RUN       = 2'b11,
      RCT_ASLEEP    = 2'b10
   } rct_state_e;
endpackage : rct_pkg

/* design/rct_sync.sv */
/*
 two flip-flop synchroniser for a vector of levels.
 assumes inputs come from pins or another clock; reset is already synchronous-released.
*/
`timescale 1ns/1ps
module rct_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rstB,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;

   // a zero-width vector cannot be synchronised
   if (WIDTH < 1) begin : g_bad_width
      $error("rct_sync: WIDTH must be at least 1");
   end

   // first stage read only by the second
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule : rct_sync

/* design/rct_timer.sv */
/*
 loadable down-counter with one-cycle done pulse, counting on an enable.
 assumes single clock; load and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
module rct_timer #(
   parameter int WIDTH = 21
) (
   input  wire logic             clk,
   input  wire logic             rstB,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadVal,
   input  wire logic             tick,
   output logic                  busy,
   output logic                  done
);
   logic [WIDTH-1:0] count;
   wire              last = busy && tick && (count == {{(WIDTH-1){1'b0}}, 1'b1});

   // the terminal compare needs at least one zero bit above the lsb
   if (WIDTH < 2) begin : g_bad_width
      $error("rct_timer: WIDTH must be at least 2");
   end

   // load wins over counting
   always_ff @(posedge clk or negedge rstB) begin
      if (!rstB) begin
         count <= '0;
         busy  <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= last;
         if (load) begin
            count <= loadVal;
            busy  <= (loadVal != '0);
         end else if (busy && tick) begin
            count <= count - 1'b1;
            busy  <= !last;
         end
      end
   end
endmodule : rct_timer

/* sim/rct_core_model.sv */
/*
 behavioural cpu core standing on the far side of the reset-cause block:
 keeps a program counter and executes sleep on request.
 assumes the same clk_sys as the block and the raw active-low rst_b.
*/
`timescale 1ns/1ps
module rct_core_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        coreResetB,
   input  wire logic        asleep,
   input  wire logic [12:0] pcLoad,
   input  wire logic        pcLoadStb,
   input  wire logic        goSleep,
   output logic             sleepEnter,
   output logic      [12:0] pcCurrent
);
   // pc follows loads, steps only while running so a wake sees a stable pc
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pcCurrent <= 13'h0000;
      end else if (pcLoadStb) begin
         pcCurrent <= pcLoad;
      end else if (coreResetB && !asleep) begin
         pcCurrent <= pcCurrent + 13'h0001;
      end
   end

   // sleep is a one-cycle pulse, only from run, never twice in a row
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sleepEnter <= 1'b0;
      end else begin
         sleepEnter <= goSleep && coreResetB && !asleep && !sleepEnter;
      end
   end
endmodule : rct_core_model

/* sim/tb_reset_cause_timeout.sv */
/*
 self-checking bench for the reset-cause and start-up time-out block.
 assumes shortened delay counts, a free oscTick of four clk_sys cycles,
 and the core model as the far side.
*/
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin fails++; $display("mismatch at %0t: %s", $time, m); end end
module tb_reset_cause_timeout;
   import rct_pkg::*;
   localparam int P = 60;
   localparam int O = 4;
   localparam int T = 4;  // oscTick period in clk_sys cycles
   localparam rct_osc_e MODES [5] = '{RCT_CRYSTAL_LOWPOWER, RCT_CRYSTAL_STD,
      RCT_CRYSTAL_FAST, RCT_INTERNAL_RC, RCT_EXTERNAL_RC};
   logic        clk_sys = 1'b0, rst_b = 1'b0, porEvt = 1'b0, masterClearB = 1'b1;
   logic        watchdogEvt = 1'b0, irqWakeEvt = 1'b0, oscTick = 1'b0, goSleep = 1'b0;
   logic        globalIrqEnable = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic [7:0]  statusIn = 8'h00, regAddr = 8'h00, regWdata = 8'h00;
   logic [7:0]  regRdata, status;
   logic [12:0] pcCurrent, pcLoad;
   logic        sleepEnter, pcLoadStb, coreResetB, asleep, irq;
   logic [1:0]  tk = 2'b00;
   int          fails = 0, checks = 0, cyc = 0;

   rct_reset_cause #(.POWERUP_DELAY_TIMER_CNT(P), .OST_CNT(O)) i_rct_reset_cause (
      .clk_sys(clk_sys), .rst_b(rst_b), .porEvt(porEvt), .masterClearB(masterClearB),
      .watchdogEvt(watchdogEvt), .irqWakeEvt(irqWakeEvt), .sleepEnter(sleepEnter),
      .oscTick(oscTick), .globalIrqEnable(globalIrqEnable), .pcCurrent(pcCurrent),
      .statusIn(statusIn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
      .regRd(regRd), .regRdata(regRdata), .pcLoad(pcLoad), .pcLoadStb(pcLoadStb),
      .status(status), .coreResetB(coreResetB), .asleep(asleep), .irq(irq));
   rct_core_model i_rct_core_model (
      .clk_sys(clk_sys), .rst_b(rst_b), .coreResetB(coreResetB), .asleep(asleep),
      .pcLoad(pcLoad), .pcLoadStb(pcLoadStb), .goSleep(goSleep),
      .sleepEnter(sleepEnter), .pcCurrent(pcCurrent));

   always #25 clk_sys = ~clk_sys;

   // oscillator input toggles every two cycles; timeout ceiling on the run
   always @(posedge clk_sys) begin
      tk <= tk + 2'b01;
      oscTick <= tk[1];
      cyc++;
      if (cyc == 30000) begin
         fails++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd

   // one-cycle pin event, then bounded wait for the pc load strobe
   task automatic fire(input int k);
      int n;
      @(posedge clk_sys);
      if (k == 6) porEvt <= 1'b1;
      else if (k == 1 || k == 2) masterClearB <= 1'b0;
      else if (k == 0 || k == 3) watchdogEvt <= 1'b1;
      else irqWakeEvt <= 1'b1;
      @(posedge clk_sys);
      porEvt <= 1'b0;
      masterClearB <= 1'b1;
      watchdogEvt <= 1'b0;
      irqWakeEvt <= 1'b0;
      #1;
      for (n = 0; n < 20 && pcLoadStb !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      `CHK(pcLoadStb, 1'b1, "no load strobe")
   endtask : fire

   task automatic sleepNow;
      int n;
      @(posedge clk_sys);
      goSleep <= 1'b1;
      for (n = 0; n < 20 && asleep !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      @(posedge clk_sys);
      goSleep <= 1'b0;
      #1;
      `CHK(asleep, 1'b1, "sleep not entered")
   endtask : sleepNow

   // counts cycles the core stays held in reset
   task automatic waitRun(output int n);
      for (n = 0; n < 400 && coreResetB !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
   endtask : waitRun

   // hold window: power-up part and oscillator part, with sync slack
   function automatic logic inRange(input int n, input logic pw, input logic os);
      int lo;
      int hi;
      lo = (pw ? P - 4 : 0) + (os ? (O - 1) * T : 0);
      hi = (pw ? P : 0) + (os ? (O + 1) * T : 0) + 8;
      return (n >= lo) && (n <= hi);
   endfunction : inRange

   function automatic logic [7:0] expStat(input int k, input logic [7:0] s);
      case (k)
         0: return {4'h0, s[3:0]};
         1: return {3'h0, s[4:0]};
         2: return {3'h0, 2'b10, s[2:0]};
         3: return {s[7:5], 2'b00, s[2:0]};
         default: return {s[7:5], 2'b10, s[2:0]};
      endcase
   endfunction : expStat

   function automatic logic [12:0] expPc(input int k, input logic [12:0] pc);
      if (k < 3) return PC_RESET;
      if (k == 5) return PC_IRQ_VEC;
      return pc + PC_STEP;
   endfunction : expPc

   // main sequence: reset, registers, events, interrupt, delay matrix
   initial begin
      logic [7:0]  d;
      logic [7:0]  w;
      logic [7:0]  s0;
      logic [12:0] pc0;
      int          n;
      void'($urandom(61910));
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(status[7:3], 5'b00011, "power-on status")
      `CHK(coreResetB, 1'b0, "core not held")
      waitRun(n);
      `CHK(inRange(n, 1'b1, 1'b1), 1'b1, "power-on delay")
      rd(ADDR_PWRCTL, d);
      `CHK(d, 8'h00, "flag after power-on")
      $display("test reset finished");
      for (int i = 0; i < 4; i++) begin
         w = 8'($urandom);
         wr(ADDR_PWRCTL, w);
         rd(ADDR_PWRCTL, d);
         `CHK(d, {6'h00, w[1], 1'b0}, "power flag readback")
      end
      rd(8'h55, d);
      `CHK(d, 8'h00, "unmapped read")
      wr(ADDR_PWRCTL, 8'hFF);
      $display("test registers finished");
      for (int k = 0; k < 6; k++) begin
         @(posedge clk_sys);
         statusIn <= 8'($urandom);
         globalIrqEnable <= (k == 5);
         if (k > 1) sleepNow();
         #1 pc0 = pcCurrent;
         s0 = statusIn;
         fire(k);
         `CHK(pcLoad, expPc(k, pc0), "pc load")
         `CHK(status, expStat(k, s0), "status load")
         waitRun(n);
         if (k > 2) `CHK(inRange(n, 1'b0, 1'b1), 1'b1, "wake start-up")
         rd(ADDR_PWRCTL, d);
         `CHK(d, 8'h02, "flag kept")
      end
      $display("test events finished");
      rd(ADDR_EVSTAT, d);
      wr(ADDR_EVMASK, 8'h00);
      fire(0);
      waitRun(n);
      `CHK(irq, 1'b0, "masked interrupt")
      wr(ADDR_EVMASK, 8'h01 << EV_WDT);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b1, "interrupt raised")
      rd(ADDR_EVSTAT, d);
      `CHK(d[EV_WDT], 1'b1, "event recorded")
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0, "interrupt cleared")
      $display("test interrupt finished");
      for (int m = 0; m < 5; m++) begin
         for (int p = 0; p < 2; p++) begin
            wr(ADDR_CONFIG, {4'h0, p[0], MODES[m]});
            fire(6);
            `CHK(status[7:3], 5'b00011, "por status")
            `CHK(pcLoad, PC_RESET, "por pc")
            waitRun(n);
            `CHK(inRange(n, p == 0, MODES[m] < RCT_INTERNAL_RC), 1'b1, "delay")
            sleepNow();
            fire(3);
            waitRun(n);
            `CHK(inRange(n, 1'b0, MODES[m] < RCT_INTERNAL_RC), 1'b1, "wake delay")
            rd(ADDR_PWRCTL, d);
            `CHK(d, 8'h00, "por clears flag")
            wr(ADDR_PWRCTL, 8'h02);
         end
      end
      $display("test delays finished");
      complete_run();
   end
endmodule : tb_reset_cause_timeout
